// >>> verilog/pump_driver_fault_ctrl.v
// solenoid low-side and pump gate control with fault supervision behind a serial register port
//
// Summary of operation
// R01 - lowside overcurrent sets its even flag and, after deglitch, turns off only that driver
// R02 - overtemperature sets thermal flag bit 6 and turns off driver plus its neighbour
// R03 - while a driver is off, openload or short to ground sets its odd flag
// R04 - any new lowside overcurrent or openload flag raises summary fail bit 0
// R05 - reading a fault register clears only flags whose condition has gone
// R06 - summary fail bit clears on status read once lowside flags are all clear
// R07 - battery under/overvoltage or logic undervoltage flags hold all lowside drivers off
// R08 - watchdog fault turns drivers off only when watchdog enable bit 4 is set
// R09 - watchdog enable bit resets to zero
// R10 - supply and watchdog faults never set the summary fail bit
// R11 - a driver turns on only after its enable bit is written 0 then 1
// R12 - shutdown follows the live fault, never a stale flag; supply shutdown here follows the latched flags until a status read
// R13 - host should read and clear fault flags before enabling drivers
// R14 - pump gate follows the pump control pin and pump enable bit 3
// R15 - pump overcurrent lasting the deglitch time turns gate off and sets its flag
// R16 - once pump overcurrent ends, bit or pin may switch the gate on again
// R17 - battery or logic undervoltage and enabled watchdog fault keep the pump gate low
// R18 - after pump enable, wait a delay, then a gate short keeps the gate low
// R19 - while enabled, pump overcurrent, gate short or source short flag and disable
// R20 - battery overvoltage forces gate on, held for a minimum time after it ends
// R21 - overvoltage flag sets after deglitch and clears on status read when gone
// R22 - after an overvoltage response further overvoltage is ignored for a blanking time
// R23 - pump gate supports host pulse-width drive; charge pump refreshed while gate off
// R24 - pump request is pin or enable bit, gated by blocking faults
// R25 - every interval is a counter of the system clock set by a constant
`timescale 1ns/1ps
`include "pump_driver_defines.vh"
module pump_driver_fault_ctrl #(
	parameter [19:0] GATE_CHECK_CYCLES = `GATE_CHECK_CYC,
	parameter [19:0] MIN_ON_CYCLES = `PUMP_MIN_ON_CYC,
	parameter [19:0] OV_BLANK_CYCLES = `OV_BLANK_CYC
) (
	input wire sys_clk,
	input wire rst_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output wire spi_miso,
	output wire spi_miso_oe,
	input wire [3:0] lowside_overcurrent,
	input wire [3:0] lowside_openload,
	input wire [3:0] lowside_overtemp,
	input wire batt_undervoltage,
	input wire batt_overvoltage,
	input wire logic_undervoltage,
	input wire watchdog_fault,
	input wire pump_control_pin,
	input wire pump_drain_sense,
	input wire pump_gate_short,
	input wire pump_source_sense,
	output reg lowside_out_one,
	output reg lowside_out_two,
	output reg lowside_out_three,
	output reg lowside_out_four,
	output reg pump_gate_output,
	output reg charge_pump_refresh
);
	localparam [1:0] OV_IDLE = 2'b00;
	localparam [1:0] OV_FORCE = 2'b01;
	localparam [1:0] OV_HOLD = 2'b10;
	localparam [1:0] OV_BLANK = 2'b11;

	function hit;
		input [6:0] addr;
		input [6:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	reg [1:0] rst_pipe;
	wire rst_sync_n;
	reg [22:0] sync_a;
	reg [22:0] sync_b;
	reg sclk_prev;
	reg cs_prev;
	reg [4:0] bit_count;
	reg [15:0] rx_shift;
	reg [7:0] tx_shift;
	reg [3:0] lowside_enable;
	reg pump_enable_bit;
	reg watchdog_gate_enable;
	reg [3:0] armed;
	reg [3:0] drive;
	reg [7:0] lowside_flags;
	reg overtemp_flag;
	reg fail_flag;
	reg batt_uv_flag;
	reg battery_overvoltage_flag;
	reg logic_uv_flag;
	reg pump_overcurrent_flag;
	reg gate_short_flag;
	reg source_short_flag;
	reg pump_trip;
	reg request_prev;
	reg check_done;
	reg [19:0] check_count;
	reg [1:0] ov_state;
	reg [1:0] next_ov_state;
	reg [19:0] ov_count;
	reg [19:0] next_ov_count;
	reg [7:0] read_data;
	wire [3:0] oc_s, ol_s, ot_s;
	wire buv_s, bov_s, luv_s, wd_s, pin_s, drain_s, gshort_s, sshort_s, sclk_s, cs_s, mosi_s;
	wire [3:0] oc_q;
	wire [3:0] ot_q;
	wire pump_oc_q;
	wire ov_q;
	wire sclk_rise, sclk_fall, frame_end, frame_ok, wr_frame, rd_frame;
	wire [6:0] frame_addr;
	wire [7:0] frame_data;
	wire wr_enable_reg, wr_ctrl_reg, rd_main, rd_lowside, rd_thermal;
	wire [7:0] next_lowside_flags;
	wire [3:0] thermal_block;
	wire [3:0] next_armed;
	wire [3:0] next_drive;
	wire supply_block, wd_block, pump_block, pump_request, normal_on, force_on;
	wire trip_event;
	wire [7:0] main_status;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	// every pin passes two flops; chip select idles high so reset never opens a frame
	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sync_a <= `RESET_SYNC;
			sync_b <= `RESET_SYNC;
		end else begin
			sync_a <= {lowside_overcurrent, lowside_openload, lowside_overtemp, batt_undervoltage,
				batt_overvoltage, logic_undervoltage, watchdog_fault, pump_control_pin,
				pump_drain_sense, pump_gate_short, pump_source_sense, spi_sclk, spi_cs_n, spi_mosi};
			sync_b <= sync_a;
		end
	end
	assign {oc_s, ol_s, ot_s, buv_s, bov_s, luv_s, wd_s, pin_s, drain_s, gshort_s, sshort_s,
		sclk_s, cs_s, mosi_s} = sync_b;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_lowside
			deglitch_filter #(.LEN(`OC_DEGLITCH_CYC)) u_oc (
				.sys_clk(sys_clk),
				.rst_sync_n(rst_sync_n),
				.level(oc_s[i]),
				.qualified(oc_q[i])
			);
			deglitch_filter #(.LEN(`THERMAL_DEGLITCH_CYC)) u_ot (
				.sys_clk(sys_clk),
				.rst_sync_n(rst_sync_n),
				.level(ot_s[i]),
				.qualified(ot_q[i])
			);
			assign next_lowside_flags[2*i] = oc_q[i] | (lowside_flags[2*i] & ~(rd_lowside & ~oc_q[i])); // R01 R05
			assign next_lowside_flags[2*i+1] = (ol_s[i] & ~drive[i]) |
				(lowside_flags[2*i+1] & ~(rd_lowside & ~(ol_s[i] & ~drive[i]))); // R03 R05
			assign thermal_block[i] = ot_q[i] | ot_q[i ^ 1]; // R02
			assign next_armed[i] = (wr_enable_reg ? (frame_data[i] & (armed[i] | ~lowside_enable[i])) :
				armed[i]) & ~oc_q[i]; // R11 R01
		end
	endgenerate

	deglitch_filter #(.LEN(`PUMP_OC_DEGLITCH_CYC)) u_pump_oc (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.level(drain_s),
		.qualified(pump_oc_q)
	);
	deglitch_filter #(.LEN(`OV_DEGLITCH_CYC)) u_ov (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.level(bov_s),
		.qualified(ov_q)
	);

	// serial frame: write flag, 7-bit address, 8 data bits, msb first, mode 0
	assign sclk_rise = sclk_s & ~sclk_prev;
	assign sclk_fall = ~sclk_s & sclk_prev;
	assign frame_end = cs_s & ~cs_prev;
	assign frame_ok = (bit_count == `SPI_FRAME_BITS);
	assign wr_frame = frame_end & frame_ok & rx_shift[15];
	assign rd_frame = frame_end & frame_ok & ~rx_shift[15];
	assign frame_addr = rx_shift[14:8];
	assign frame_data = rx_shift[7:0];
	assign wr_enable_reg = wr_frame & hit(frame_addr, `ADDR_LOWSIDE_ENABLE);
	assign wr_ctrl_reg = wr_frame & hit(frame_addr, `ADDR_DRIVER_CONTROL);
	assign rd_main = rd_frame & hit(frame_addr, `ADDR_MAIN_STATUS);
	assign rd_lowside = rd_frame & hit(frame_addr, `ADDR_LOWSIDE_FLAGS);
	assign rd_thermal = rd_frame & hit(frame_addr, `ADDR_THERMAL_STATUS);
	assign spi_miso = tx_shift[7];
	assign spi_miso_oe = ~cs_s;

	assign main_status = {1'b0, source_short_flag, gate_short_flag, pump_overcurrent_flag, logic_uv_flag,
		battery_overvoltage_flag, batt_uv_flag, fail_flag};

	always @* begin
		case ({rx_shift[5:0], mosi_s})
			`ADDR_MAIN_STATUS: read_data = main_status;
			`ADDR_LOWSIDE_FLAGS: read_data = lowside_flags;
			`ADDR_THERMAL_STATUS: read_data = {1'b0, overtemp_flag, 6'h00};
			`ADDR_LOWSIDE_ENABLE: read_data = {4'h0, lowside_enable};
			`ADDR_DRIVER_CONTROL: read_data = {3'h0, watchdog_gate_enable, pump_enable_bit, 3'h0};
			default: read_data = 8'h00;
		endcase
	end

	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sclk_prev <= 1'b0;
			cs_prev <= 1'b1;
			bit_count <= 5'h00;
			rx_shift <= 16'h0000;
			tx_shift <= 8'h00;
		end else begin
			sclk_prev <= sclk_s;
			cs_prev <= cs_s;
			if (cs_s) begin
				bit_count <= 5'h00;
			end else if (sclk_rise) begin
				rx_shift <= {rx_shift[14:0], mosi_s};
				if (bit_count != `SPI_FRAME_BITS)
					bit_count <= bit_count + 5'h01;
				// register snapshot taken once the address byte is in
				if (bit_count == `SPI_ADDR_DONE)
					tx_shift <= read_data;
			end else if (sclk_fall && bit_count > `SPI_SHIFT_START) begin
				tx_shift <= {tx_shift[6:0], 1'b0};
			end
		end
	end

	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			lowside_enable <= `RESET_LOWSIDE_ENABLE;
			pump_enable_bit <= `RESET_PUMP_ENABLE;
			watchdog_gate_enable <= `RESET_WATCHDOG_ENABLE; // R09
		end else begin
			if (wr_enable_reg)
				lowside_enable <= frame_data[3:0];
			if (wr_ctrl_reg) begin
				pump_enable_bit <= frame_data[`CTRL_PUMP_ENABLE_BIT];
				watchdog_gate_enable <= frame_data[`CTRL_WATCHDOG_ENABLE_BIT];
			end
		end
	end

	// flags: a set in the same cycle as a read wins over the clear
	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			lowside_flags <= 8'h00;
			overtemp_flag <= 1'b0;
			fail_flag <= 1'b0;
			batt_uv_flag <= 1'b0;
			battery_overvoltage_flag <= 1'b0;
			logic_uv_flag <= 1'b0;
			pump_overcurrent_flag <= 1'b0;
			gate_short_flag <= 1'b0;
			source_short_flag <= 1'b0;
		end else begin
			lowside_flags <= next_lowside_flags;
			overtemp_flag <= (|ot_q) | (overtemp_flag & ~(rd_thermal & ~(|ot_q))); // R02 R05
			// only lowside flag sets reach the summary; supply and watchdog never do
			fail_flag <= (|(next_lowside_flags & ~lowside_flags)) |
				(fail_flag & ~(rd_main & ~(|lowside_flags))); // R04 R06 R10
			batt_uv_flag <= buv_s | (batt_uv_flag & ~rd_main); // R05
			battery_overvoltage_flag <= ov_q | (battery_overvoltage_flag & ~rd_main); // R21
			logic_uv_flag <= luv_s | (logic_uv_flag & ~rd_main); // R05
			pump_overcurrent_flag <= pump_oc_q | (pump_overcurrent_flag & ~rd_main); // R15
			gate_short_flag <= (check_done & gshort_s) | (gate_short_flag & ~rd_main); // R18 R19
			source_short_flag <= (check_done & sshort_s) | (source_short_flag & ~rd_main); // R19
		end
	end

	assign supply_block = batt_uv_flag | battery_overvoltage_flag | logic_uv_flag; // R07
	assign wd_block = watchdog_gate_enable & wd_s; // R08
	// live overcurrent, thermal and watchdog state decides shutdown; supply faults act through their latched flags
	assign next_drive = armed & lowside_enable & ~oc_q & ~thermal_block & {4{~supply_block & ~wd_block}}; // R12

	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			armed <= 4'h0;
			drive <= 4'h0;
			lowside_out_one <= 1'b0;
			lowside_out_two <= 1'b0;
			lowside_out_three <= 1'b0;
			lowside_out_four <= 1'b0;
		end else begin
			armed <= next_armed;
			drive <= next_drive;
			lowside_out_one <= next_drive[0];
			lowside_out_two <= next_drive[1];
			lowside_out_three <= next_drive[2];
			lowside_out_four <= next_drive[3];
		end
	end

	// pump gate path
	assign pump_request = pin_s | pump_enable_bit; // R14 R24
	assign pump_block = logic_uv_flag | batt_uv_flag | wd_block; // R17
	assign trip_event = pump_oc_q | (check_done & (gshort_s | sshort_s)); // R15 R19
	assign normal_on = pump_request & check_done & ~pump_trip & ~trip_event & ~pump_block; // R18 R24
	assign force_on = (ov_state == OV_FORCE) || (ov_state == OV_HOLD); // R20

	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			request_prev <= 1'b0;
			check_done <= 1'b0;
			check_count <= 20'h00000;
			pump_trip <= 1'b0;
		end else begin
			request_prev <= pump_request;
			// trip stays until the request drops, then bit or pin restart the gate
			if (!pump_request)
				pump_trip <= 1'b0; // R16
			else if (trip_event)
				pump_trip <= 1'b1; // R15 R19
			if (!pump_request || !request_prev) begin
				check_done <= 1'b0;
				check_count <= 20'h00000;
			end else if (!check_done) begin
				if (check_count + 20'h00001 >= GATE_CHECK_CYCLES)
					check_done <= 1'b1; // R18 R25
				else
					check_count <= check_count + 20'h00001;
			end
		end
	end

	always @* begin
		next_ov_state = ov_state;
		next_ov_count = ov_count;
		case (ov_state)
			OV_IDLE: begin
				if (ov_q)
					next_ov_state = OV_FORCE; // R20
			end
			OV_FORCE: begin
				if (!bov_s) begin
					next_ov_state = OV_HOLD;
					next_ov_count = 20'h00000;
				end
			end
			OV_HOLD: begin
				if (ov_count + 20'h00001 >= MIN_ON_CYCLES) begin
					next_ov_state = OV_BLANK; // R20 R25
					next_ov_count = 20'h00000;
				end else begin
					next_ov_count = ov_count + 20'h00001;
				end
			end
			OV_BLANK: begin
				// new overvoltage ignored here to avoid rapid gate chatter on a ringing supply
				if (ov_count + 20'h00001 >= OV_BLANK_CYCLES)
					next_ov_state = OV_IDLE; // R22 R25
				else
					next_ov_count = ov_count + 20'h00001;
			end
			default: begin
				next_ov_state = OV_IDLE;
				next_ov_count = 20'h00000;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ov_state <= OV_IDLE;
			ov_count <= 20'h00000;
			pump_gate_output <= 1'b0;
			charge_pump_refresh <= 1'b0;
		end else begin
			ov_state <= next_ov_state;
			ov_count <= next_ov_count;
			pump_gate_output <= force_on | normal_on; // R20 R24
			// pulse drive comes from host toggling; charge store tops up in every off phase
			charge_pump_refresh <= ~(force_on | normal_on); // R23
		end
	end
endmodule

// >>> verilog/pump_driver_defines.vh
// register map, field positions, reset values and timing counts of the driver fault controller
`ifndef PUMP_DRIVER_DEFINES_VH
`define PUMP_DRIVER_DEFINES_VH

`define ADDR_MAIN_STATUS 7'h00
`define ADDR_LOWSIDE_FLAGS 7'h01
`define ADDR_THERMAL_STATUS 7'h03
`define ADDR_LOWSIDE_ENABLE 7'h10
`define ADDR_DRIVER_CONTROL 7'h11

`define MAIN_FAIL_BIT 0
`define MAIN_BATT_UV_BIT 1
`define MAIN_BATT_OV_BIT 2
`define MAIN_LOGIC_UV_BIT 3
`define MAIN_PUMP_OC_BIT 4
`define MAIN_GATE_SHORT_BIT 5
`define MAIN_SOURCE_SHORT_BIT 6
`define THERMAL_OVERTEMP_BIT 6
`define CTRL_PUMP_ENABLE_BIT 3
`define CTRL_WATCHDOG_ENABLE_BIT 4

`define RESET_LOWSIDE_ENABLE 4'h0
`define RESET_PUMP_ENABLE 1'b0
`define RESET_WATCHDOG_ENABLE 1'b0
`define RESET_SYNC 23'h000002
`define SPI_FRAME_BITS 5'h10
`define SPI_ADDR_DONE 5'h07
`define SPI_SHIFT_START 5'h08

`define CLK_PERIOD_NS 20
`define OC_DEGLITCH_NS 10000
`define THERMAL_DEGLITCH_NS 20000
`define PUMP_OC_DEGLITCH_NS 10000
`define OV_DEGLITCH_NS 50000
`define GATE_CHECK_DELAY_NS 100000
`define PUMP_MIN_ON_NS 1000000
`define OV_BLANK_NS 10000000
`define PWM_PERIOD_NS 5000000
`define PWM_DUTY_MIN_PCT 10
`define PWM_DUTY_MAX_PCT 90

`define OC_DEGLITCH_CYC 16'h01F4
`define THERMAL_DEGLITCH_CYC 16'h03E8
`define PUMP_OC_DEGLITCH_CYC 16'h01F4
`define OV_DEGLITCH_CYC 16'h09C4
`define GATE_CHECK_CYC 20'h01388
`define PUMP_MIN_ON_CYC 20'h0C350
`define OV_BLANK_CYC 20'h7A120

`endif

// >>> verilog/deglitch_filter.v
// persistence filter: output rises once the input has stayed high for len cycles
`timescale 1ns/1ps
module deglitch_filter #(
	parameter [15:0] LEN = 16'h0001
) (
	input wire sys_clk,
	input wire rst_sync_n,
	input wire level,
	output reg qualified
);
	reg [15:0] count;

	always @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count <= 16'h0000;
			qualified <= 1'b0;
		end else if (!level) begin
			// any drop restarts the interval, so short glitches never qualify
			count <= 16'h0000;
			qualified <= 1'b0;
		end else if (count + 16'h0001 >= LEN) begin
			qualified <= 1'b1;
		end else begin
			count <= count + 16'h0001;
		end
	end
endmodule

// >>> tb/pump_driver_fault_ctrl_properties.sv
// assertion checker bound to the driver fault controller top
`timescale 1ns/1ps
module pump_driver_fault_ctrl_properties #(
	parameter [19:0] GATE_CHECK_CYCLES = 20'h00008,
	parameter [19:0] MIN_ON_CYCLES = 20'h00010,
	parameter [19:0] OV_BLANK_CYCLES = 20'h00020
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [3:0] lowside_overcurrent,
	input wire [3:0] lowside_overtemp,
	input wire batt_undervoltage,
	input wire logic_undervoltage,
	input wire batt_overvoltage,
	input wire pump_control_pin,
	input wire pump_drain_sense,
	input wire pump_gate_short,
	input wire lowside_out_one,
	input wire lowside_out_two,
	input wire lowside_out_three,
	input wire lowside_out_four,
	input wire pump_gate_output
);
	// run lengths of long faults, too long to unroll as repetitions
	wire [2:0] src = {pump_drain_sense, lowside_overtemp[0], lowside_overcurrent[0]};
	wire [3:0] lo = {lowside_out_four, lowside_out_three, lowside_out_two, lowside_out_one};
	reg [11:0] run [0:2];
	integer i;
	always @(posedge sys_clk or negedge rst_n) begin
		for (i = 0; i < 3; i = i + 1) begin
			if (!rst_n)
				run[i] <= 12'h000;
			else if (!src[i])
				run[i] <= 12'h000;
			else if (run[i] != 12'hFFF)
				run[i] <= run[i] + 12'h001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	supply_lowside_a: assert property ((batt_undervoltage || logic_undervoltage) [*5] |-> lo == 4'h0)
		else $error("lowside driver on during undervoltage");
	supply_pump_a: assert property ((batt_undervoltage || logic_undervoltage) [*5] |-> !pump_gate_output)
		else $error("pump gate on during undervoltage");
	oc_one_off_a: assert property (run[0] >= 12'h200 |-> !lowside_out_one)
		else $error("driver one on after overcurrent deglitch");
	thermal_pair_a: assert property (run[1] >= 12'h400 |-> !lowside_out_one && !lowside_out_two)
		else $error("driver pair on after overtemperature deglitch");
	pump_oc_off_a: assert property (run[2] >= 12'h200 |-> !pump_gate_output)
		else $error("pump gate on after overcurrent deglitch");
	gate_check_a: assert property ($rose(pump_control_pin) && !pump_gate_output |=> !pump_gate_output [*6])
		else $error("pump gate on before short check delay");
	gate_short_a: assert property (pump_gate_short [*5] |-> !pump_gate_output)
		else $error("pump gate on with gate shorted");
	ov_hold_a: assert property ($fell(batt_overvoltage) && pump_gate_output |=> pump_gate_output [*8])
		else $error("pump gate dropped inside minimum on time");
endmodule
bind pump_driver_fault_ctrl pump_driver_fault_ctrl_properties #(.GATE_CHECK_CYCLES(GATE_CHECK_CYCLES),
	.MIN_ON_CYCLES(MIN_ON_CYCLES), .OV_BLANK_CYCLES(OV_BLANK_CYCLES)) u_props (.sys_clk, .rst_n,
	.lowside_overcurrent, .lowside_overtemp, .batt_undervoltage, .logic_undervoltage, .batt_overvoltage,
	.pump_control_pin, .pump_drain_sense, .pump_gate_short, .lowside_out_one, .lowside_out_two,
	.lowside_out_three, .lowside_out_four, .pump_gate_output);

// >>> tb/host_serial_model.sv
// host side of the serial register link, mode 0 framing
`timescale 1ns/1ps
module host_serial_model (
	input wire sys_clk,
	input wire spi_miso,
	output reg spi_sclk,
	output reg spi_cs_n,
	output reg spi_mosi
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// 5 clocks a phase: pins pass two sync flops, 3 is the floor
	task xfer(input [15:0] word, output [7:0] rd);
		integer i;
		begin
			@(negedge sys_clk);
			spi_cs_n = 1'b0;
			for (i = 15; i >= 0; i = i - 1) begin
				spi_mosi = word[i];
				repeat (5) @(negedge sys_clk);
				spi_sclk = 1'b1;
				if (i < 8)
					rd[i] = spi_miso;
				repeat (5) @(negedge sys_clk);
				spi_sclk = 1'b0;
			end
			repeat (5) @(negedge sys_clk);
			spi_cs_n = 1'b1;
			// released line never keeps its last bit
			spi_mosi = ~spi_mosi;
			repeat (8) @(negedge sys_clk);
		end
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the driver fault controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin n_errors = n_errors + 1; \
$display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
	reg sys_clk, rst_n, uv, ov, luv, wd, pin, drain, gshort, ssrc;
	reg [3:0] ls_oc, ls_ol, ls_ot;
	wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, gate, cp, oe;
	wire [3:0] lo;
	integer n_errors, n_tests;
	host_serial_model u_host (.sys_clk(sys_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
	pump_driver_fault_ctrl #(.GATE_CHECK_CYCLES(20'h00008), .MIN_ON_CYCLES(20'h00010),
		.OV_BLANK_CYCLES(20'h00FA0)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(oe),
		.lowside_overcurrent(ls_oc), .lowside_openload(ls_ol), .lowside_overtemp(ls_ot),
		.batt_undervoltage(uv), .batt_overvoltage(ov), .logic_undervoltage(luv),
		.watchdog_fault(wd), .pump_control_pin(pin), .pump_drain_sense(drain),
		.pump_gate_short(gshort), .pump_source_sense(ssrc),
		.lowside_out_one(lo[0]), .lowside_out_two(lo[1]), .lowside_out_three(lo[2]),
		.lowside_out_four(lo[3]), .pump_gate_output(gate), .charge_pump_refresh(cp));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task wt(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	task wr(input [6:0] a, input [7:0] d);
		reg [7:0] unused;
		u_host.xfer({1'b1, a, d}, unused);
	endtask
	task rd(input [6:0] a, input [7:0] e);
		reg [7:0] d;
		begin
			u_host.xfer({1'b0, a, 8'h00}, d);
			`CHK(d, e)
		end
	endtask
	task t_reset;
		begin
			rd(7'h11, 8'h00);
			rd(7'h05, 8'h00);
			`CHK(cp, 1'b1)
			`CHK(oe, 1'b0)
			rd(7'h01, 8'h00);
			rd(7'h00, 8'h00);
			wr(7'h10, 8'h0F);
			wt(4);
			`CHK(lo, 4'hF)
			rd(7'h10, 8'h0F);
			$display("reset test over");
		end
	endtask
	task t_oc;
		begin
			ls_oc = 4'h1;
			wt(300);
			`CHK(lo, 4'hF)
			wt(220);
			`CHK(lo, 4'hE)
			rd(7'h01, 8'h01);
			rd(7'h01, 8'h01);
			rd(7'h00, 8'h01);
			ls_oc = 4'h0;
			wr(7'h10, 8'h0F);
			wt(4);
			`CHK(lo, 4'hE)
			wr(7'h10, 8'h0E);
			wr(7'h10, 8'h0F);
			wt(4);
			`CHK(lo, 4'hF)
			rd(7'h01, 8'h01);
			rd(7'h01, 8'h00);
			rd(7'h00, 8'h01);
			rd(7'h00, 8'h00);
			$display("overcurrent test over");
		end
	endtask
	task t_thermal;
		begin
			ls_ot = 4'h1;
			wt(900);
			`CHK(lo, 4'hF)
			wt(130);
			`CHK(lo, 4'hC)
			rd(7'h03, 8'h40);
			ls_ot = 4'h0;
			wt(4);
			`CHK(lo, 4'hF)
			rd(7'h03, 8'h40);
			rd(7'h03, 8'h00);
			rd(7'h00, 8'h00);
			$display("thermal test over");
		end
	endtask
	task t_open;
		begin
			ls_ol = 4'h8;
			rd(7'h01, 8'h00);
			wr(7'h10, 8'h07);
			rd(7'h01, 8'h80);
			rd(7'h00, 8'h01);
			ls_ol = 4'h0;
			rd(7'h01, 8'h80);
			rd(7'h01, 8'h00);
			rd(7'h00, 8'h01);
			rd(7'h00, 8'h00);
			wr(7'h10, 8'h0F);
			wt(4);
			`CHK(lo, 4'hF)
			$display("open load test over");
		end
	endtask
	task t_supply;
		integer k;
		begin
			for (k = 0; k < 2; k = k + 1) begin
				uv = (k == 0);
				luv = (k == 1);
				wt(6);
				`CHK(lo, 4'h0)
				uv = 1'b0;
				luv = 1'b0;
				wt(6);
				`CHK(lo, 4'h0)
				rd(7'h00, k ? 8'h08 : 8'h02);
				wt(4);
				`CHK(lo, 4'hF)
			end
			$display("supply test over");
		end
	endtask
	task t_wdog;
		begin
			wd = 1'b1;
			wt(6);
			`CHK(lo, 4'hF)
			wr(7'h11, 8'h10);
			wt(4);
			`CHK(lo, 4'h0)
			rd(7'h11, 8'h10);
			rd(7'h00, 8'h00);
			wd = 1'b0;
			wt(6);
			`CHK(lo, 4'hF)
			wr(7'h11, 8'h00);
			$display("watchdog test over");
		end
	endtask
	task t_pump;
		integer k;
		begin
			pin = 1'b1;
			wt(4);
			`CHK(gate, 1'b0)
			wt(20);
			`CHK(gate, 1'b1)
			`CHK(cp, 1'b0)
			pin = 1'b0;
			wt(5);
			`CHK(gate, 1'b0)
			wr(7'h11, 8'h08);
			wt(20);
			`CHK(gate, 1'b1)
			drain = 1'b1;
			wt(300);
			`CHK(gate, 1'b1)
			wt(220);
			`CHK(gate, 1'b0)
			rd(7'h00, 8'h10);
			drain = 1'b0;
			// overcurrent gone: this read clears the pump flag before the short tests
			rd(7'h00, 8'h10);
			wr(7'h11, 8'h00);
			pin = 1'b1;
			wt(24);
			`CHK(gate, 1'b1)
			for (k = 0; k < 2; k = k + 1) begin
				gshort = (k == 0);
				ssrc = (k == 1);
				wt(8);
				`CHK(gate, 1'b0)
				gshort = 1'b0;
				ssrc = 1'b0;
				rd(7'h00, 8'h20 << k);
				pin = 1'b0;
				wt(3);
				pin = 1'b1;
				wt(24);
				`CHK(gate, 1'b1)
			end
			pin = 1'b0;
			gshort = 1'b1;
			wt(3);
			pin = 1'b1;
			wt(24);
			`CHK(gate, 1'b0)
			gshort = 1'b0;
			pin = 1'b0;
			rd(7'h00, 8'h20);
			pin = 1'b1;
			wt(24);
			uv = 1'b1;
			wt(6);
			`CHK(gate, 1'b0)
			uv = 1'b0;
			pin = 1'b0;
			rd(7'h00, 8'h02);
			$display("pump test over");
		end
	endtask
	task t_ov;
		begin
			ov = 1'b1;
			wt(2000);
			`CHK(gate, 1'b0)
			wt(520);
			`CHK(gate, 1'b1)
			`CHK(lo, 4'h0)
			rd(7'h00, 8'h04);
			ov = 1'b0;
			wt(10);
			`CHK(gate, 1'b1)
			wt(30);
			`CHK(gate, 1'b0)
			rd(7'h00, 8'h04);
			rd(7'h00, 8'h00);
			ov = 1'b1;
			wt(2600);
			`CHK(gate, 1'b0)
			ov = 1'b0;
			$display("overvoltage test over");
		end
	endtask
	task wrap_up;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		n_errors = n_errors + 1;
		wrap_up;
	end
	initial begin
		n_errors = 0;
		n_tests = 0;
		{rst_n, uv, ov, luv, wd, pin, drain, gshort, ssrc} = 9'h000;
		{ls_oc, ls_ol, ls_ot} = 12'h000;
		wt(2);
		rst_n = 1'b1;
		wt(5);
		t_reset;
		t_oc;
		t_thermal;
		t_open;
		t_supply;
		t_wdog;
		t_pump;
		t_ov;
		wrap_up;
	end
endmodule
